// file: inc/brla_cfg.svh
`ifndef BRLA_CFG_SVH
`define BRLA_CFG_SVH

// Training offsets in bauds, counted from the end of the wake-up tone
`define BRLA_OFF_SILENT_END 14'h0040
`define BRLA_OFF_NT_BURST1  14'h0240
`define BRLA_OFF_LT_BURST2  14'h0440
`define BRLA_OFF_NT_BURST2  14'h0640
`define BRLA_OFF_LT_PRBS    14'h0840
`define BRLA_OFF_NT_PRBS    14'h1860
`define BRLA_OFF_TERNARY    14'h2840
`define BRLA_OFF_W          14

// Wake-up tone: 32 cycles of +--+, each cycle four bauds, never above 10 ms
`define BRLA_TONE_CYCLES    32
`define BRLA_TONE_BAUDS     8'h80
`define BRLA_TONE_MAX_MS    10

// Supervision timer
`define BRLA_CLK_HZ         10000000
`define BRLA_SUPV_TIME_MS   65
`define BRLA_SUPV_CYCLES    (`BRLA_SUPV_TIME_MS * (`BRLA_CLK_HZ / 1000))
`define BRLA_SUPV_W         20

// Training pattern generator
`define BRLA_PRBS_SEED      9'h1ff

`endif

// file: inc/brla_pkg.sv
package brla_pkg;

  typedef enum logic [2:0] {
    BRLA_READY_STATE          = 3'h0,
    BRLA_TRAINING_STATE       = 3'h1,
    BRLA_WAIT_TERMINAL_STATE  = 3'h2,
    BRLA_WAIT_DATA_VALID_STATE = 3'h3,
    BRLA_STEADY_STATE_OPERATION = 3'h4,
    BRLA_TERMINAL_ACTIVATION_STATE = 3'h5,
    BRLA_PENDING_DEACTIVATION_STATE = 3'h6
  } brla_state_t;

  typedef enum logic [2:0] {
    BRLA_INFO0 = 3'h0,
    BRLA_INFO1 = 3'h1,
    BRLA_INFO2 = 3'h2,
    BRLA_INFO3 = 3'h3,
    BRLA_INFO4 = 3'h4
  } brla_info_t;

  typedef enum logic [1:0] {
    BRLA_SYM_ZERO  = 2'h0,
    BRLA_SYM_PLUS  = 2'h1,
    BRLA_SYM_MINUS = 2'h2
  } brla_sym_t;

endpackage : brla_pkg

// file: core/brla_nt_core.sv
`timescale 1ns/1ps
// Operation
// - LT counts offsets from tone end sent; NT from detected tone end.
// - Delay from LT tone end to NT detecting it is at most 32 bauds.
// - 64 silent bauds, then four 512-baud timing bursts: LT, NT, LT, NT.
// - LT PRBS at 2112 for 4096 bauds; NT PRBS without timing from 6240.
// - Training pattern is the 511-bit sequence of 1 xor x^-4 xor x^-9.
// - From offset 10304 LT sends ternary data continuously with timing.
// - NT withholds ternary data until synchronized; about 405 bauds is typical.
// - NT sends ternary only after error-free reception; it waits for frame alignment only if ALIGN_EN.
// - Wait before first NT ternary may align frame words; optional.
// - NT state flow and terminal INFO outputs per state.
// - INFO 1 in ready goes to terminal activation; sync loss goes pending.
// - Pending deactivation ignores events; returns to ready when line silent.
// - Wake-up tone of +--+ lasts at least 32 cycles, at most 10 ms.
// - Supervision timer ends operation within 65 ms of missing sync.
`include "brla_cfg.svh"

module brla_nt_core #(
  parameter int unsigned SUPV_CYCLES = `BRLA_SUPV_CYCLES,
  parameter int unsigned DW          = 2
) (
  input  wire logic          CLK_SYS,
  input  wire logic          SYS_RST,
  input  wire logic          LINE_CLK,
  input  wire logic          TONE_DET,
  input  wire logic          LINE_SIG_DET,
  input  wire logic          IN_SYNC,
  input  wire logic          DATA_VALID,
  input  wire logic [2:0]    TE_INFO,
  input  wire logic          ALIGN_EN,
  input  wire logic          FRAME_ALIGN,
  input  wire logic [DW-1:0] TX_SYM,
  input  wire logic          TX_VALID,
  output logic               TX_READY,
  output logic [1:0]         LINE_SYM,
  output logic               LINE_TIMING,
  output logic               LINE_TERNARY,
  output logic [2:0]         TE_INFO_OUT,
  output logic [2:0]         NT_STATE
);

  localparam int unsigned SW = `BRLA_SUPV_W;

  function automatic brla_pkg::brla_info_t info_of(input brla_pkg::brla_state_t s);
    case (s)
      brla_pkg::BRLA_WAIT_TERMINAL_STATE,
      brla_pkg::BRLA_WAIT_DATA_VALID_STATE:  info_of = brla_pkg::BRLA_INFO2;
      brla_pkg::BRLA_STEADY_STATE_OPERATION: info_of = brla_pkg::BRLA_INFO4;
      default:                               info_of = brla_pkg::BRLA_INFO0;
    endcase
  endfunction : info_of

  // Pins from outside: two flops, then a third stage for edge finding
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [3:0] sync3_r;

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      sync3_r <= 4'h0;
    end else begin
      sync1_r <= {LINE_CLK, TONE_DET, LINE_SIG_DET, IN_SYNC};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  logic baud_tick;
  logic tone_rise;
  logic tone_fall;
  logic line_sig;
  logic in_sync;
  logic sync_fall;

  assign baud_tick = sync2_r[3] & ~sync3_r[3];
  assign tone_rise = sync2_r[2] & ~sync3_r[2];
  assign tone_fall = ~sync2_r[2] & sync3_r[2];
  assign line_sig  = sync2_r[1];
  assign in_sync   = sync2_r[0];
  assign sync_fall = ~sync2_r[0] & sync3_r[0];

  brla_pkg::brla_state_t state_r;
  brla_pkg::brla_state_t state_nxt;
  logic [`BRLA_OFF_W-1:0] off_r;
  logic                   run_r;
  logic [SW-1:0]          supv_r;
  logic                   supv_exp;
  logic                   at_ternary;

  assign at_ternary = run_r && (off_r == `BRLA_OFF_TERNARY);
  assign supv_exp   = (supv_r == SW'(SUPV_CYCLES - 1));

  // NT activation state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      brla_pkg::BRLA_READY_STATE: begin
        if (tone_rise)
          state_nxt = brla_pkg::BRLA_TRAINING_STATE;
        else if (TE_INFO == brla_pkg::BRLA_INFO1)
          state_nxt = brla_pkg::BRLA_TERMINAL_ACTIVATION_STATE;
      end
      brla_pkg::BRLA_TRAINING_STATE: begin
        if (sync_fall || supv_exp)
          state_nxt = brla_pkg::BRLA_PENDING_DEACTIVATION_STATE;
        else if (in_sync)
          state_nxt = brla_pkg::BRLA_WAIT_TERMINAL_STATE;
      end
      brla_pkg::BRLA_WAIT_TERMINAL_STATE: begin
        if (!in_sync)
          state_nxt = brla_pkg::BRLA_PENDING_DEACTIVATION_STATE;
        else if (TE_INFO == brla_pkg::BRLA_INFO3)
          state_nxt = brla_pkg::BRLA_WAIT_DATA_VALID_STATE;
      end
      brla_pkg::BRLA_WAIT_DATA_VALID_STATE: begin
        if (!in_sync)
          state_nxt = brla_pkg::BRLA_PENDING_DEACTIVATION_STATE;
        else if (DATA_VALID)
          state_nxt = brla_pkg::BRLA_STEADY_STATE_OPERATION;
      end
      brla_pkg::BRLA_STEADY_STATE_OPERATION: begin
        if (!in_sync)
          state_nxt = brla_pkg::BRLA_PENDING_DEACTIVATION_STATE;
      end
      brla_pkg::BRLA_TERMINAL_ACTIVATION_STATE: begin
        if (tone_rise)
          state_nxt = brla_pkg::BRLA_TRAINING_STATE;
      end
      brla_pkg::BRLA_PENDING_DEACTIVATION_STATE: begin
        if (!line_sig)
          state_nxt = brla_pkg::BRLA_READY_STATE;
      end
      default: state_nxt = brla_pkg::BRLA_READY_STATE;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      state_r     <= brla_pkg::BRLA_READY_STATE;
      NT_STATE    <= 3'h0;
      TE_INFO_OUT <= 3'h0;
    end else begin
      state_r     <= state_nxt;
      NT_STATE    <= state_nxt;
      TE_INFO_OUT <= info_of(state_nxt);
    end
  end

  // Baud offset counter, origin at detected end of wake-up tone
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      off_r <= '0;
      run_r <= 1'b0;
    end else if (state_r == brla_pkg::BRLA_READY_STATE ||
                 state_r == brla_pkg::BRLA_TERMINAL_ACTIVATION_STATE ||
                 state_r == brla_pkg::BRLA_PENDING_DEACTIVATION_STATE) begin
      off_r <= '0;
      run_r <= 1'b0;
    end else if (state_r == brla_pkg::BRLA_TRAINING_STATE && tone_fall && !run_r) begin
      off_r <= '0;
      run_r <= 1'b1;
    end else if (run_r && baud_tick && !at_ternary) begin
      off_r <= off_r + 1'b1;
    end
  end

  // Supervision after the point where sync should have been reached
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST)
      supv_r <= '0;
    else if (state_r == brla_pkg::BRLA_TRAINING_STATE && at_ternary && !in_sync)
      supv_r <= supv_r + 1'b1;
    else
      supv_r <= '0;
  end

  // Training phase decode
  logic nt_burst;
  logic prbs_ph;

  assign nt_burst = state_r == brla_pkg::BRLA_TRAINING_STATE && run_r &&
                    ((off_r >= `BRLA_OFF_NT_BURST1 && off_r < `BRLA_OFF_LT_BURST2) ||
                     (off_r >= `BRLA_OFF_NT_BURST2 && off_r < `BRLA_OFF_LT_PRBS));
  assign prbs_ph  = state_r == brla_pkg::BRLA_TRAINING_STATE && run_r &&
                    off_r >= `BRLA_OFF_NT_PRBS && off_r < `BRLA_OFF_TERNARY;

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST)
      LINE_TIMING <= 1'b0;
    else
      LINE_TIMING <= nt_burst;
  end

  logic [8:0] lfsr_r;

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || !prbs_ph)
      lfsr_r <= `BRLA_PRBS_SEED;
    else if (baud_tick)
      lfsr_r <= {lfsr_r[7:0], lfsr_r[8] ^ lfsr_r[3]};
  end

  // Ternary release: synchronized, LT ternary running, optional frame alignment
  logic in_sync_state;

  assign in_sync_state = state_r == brla_pkg::BRLA_WAIT_TERMINAL_STATE ||
                         state_r == brla_pkg::BRLA_WAIT_DATA_VALID_STATE ||
                         state_r == brla_pkg::BRLA_STEADY_STATE_OPERATION;

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST)
      LINE_TERNARY <= 1'b0;
    else
      LINE_TERNARY <= in_sync_state && in_sync && at_ternary &&
                      (!ALIGN_EN || FRAME_ALIGN || LINE_TERNARY);
  end

  // Wake-up tone sent while waiting for the line in terminal activation
  logic [7:0] tone_cnt_r;
  logic       tone_on;

  assign tone_on = state_r == brla_pkg::BRLA_TERMINAL_ACTIVATION_STATE &&
                   tone_cnt_r < `BRLA_TONE_BAUDS;

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || state_r != brla_pkg::BRLA_TERMINAL_ACTIVATION_STATE)
      tone_cnt_r <= 8'h00;
    else if (baud_tick && tone_on)
      tone_cnt_r <= tone_cnt_r + 8'h01;
  end

  // Two-entry buffer between user data and the line
  logic [DW-1:0] mem_r [2];
  logic          wr_r;
  logic          rd_r;
  logic [1:0]    cnt_r;
  logic          push;
  logic          pop;

  assign push = TX_VALID && TX_READY;
  assign pop  = baud_tick && !tone_on && !prbs_ph && LINE_TERNARY && cnt_r != 2'h0;

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      wr_r     <= 1'b0;
      rd_r     <= 1'b0;
      cnt_r    <= 2'h0;
      TX_READY <= 1'b0;
      mem_r[0] <= '0;
      mem_r[1] <= '0;
    end else begin
      if (push) begin
        mem_r[wr_r] <= TX_SYM;
        wr_r        <= ~wr_r;
      end
      if (pop)
        rd_r <= ~rd_r;
      cnt_r    <= cnt_r + {1'b0, push} - {1'b0, pop};
      TX_READY <= (cnt_r + {1'b0, push} - {1'b0, pop}) != 2'h2;
    end
  end

  // Line symbol, one per baud
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST)
      LINE_SYM <= brla_pkg::BRLA_SYM_ZERO;
    else if (baud_tick) begin
      if (tone_on)
        LINE_SYM <= (tone_cnt_r[1:0] == 2'h1 || tone_cnt_r[1:0] == 2'h2) ?
                    brla_pkg::BRLA_SYM_MINUS : brla_pkg::BRLA_SYM_PLUS;
      else if (prbs_ph)
        LINE_SYM <= lfsr_r[8] ? brla_pkg::BRLA_SYM_PLUS : brla_pkg::BRLA_SYM_MINUS;
      else if (pop)
        LINE_SYM <= 2'(mem_r[rd_r]);
      else
        LINE_SYM <= brla_pkg::BRLA_SYM_ZERO;
    end
  end

  chk_origin_zero: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state_r == brla_pkg::BRLA_TRAINING_STATE && tone_fall && !run_r) |=> (off_r == '0 && run_r))
    else $error("offset origin not set at tone end");

  chk_silent_start: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (run_r && off_r < `BRLA_OFF_NT_BURST1) |=> !LINE_TIMING)
    else $error("timing sent before first NT burst");

  chk_nt_burst_on: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state_r == brla_pkg::BRLA_TRAINING_STATE && run_r &&
     off_r >= `BRLA_OFF_NT_BURST2 && off_r < `BRLA_OFF_LT_PRBS) |=> LINE_TIMING)
    else $error("NT timing burst missing");

  chk_prbs_no_timing: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    prbs_ph |=> !LINE_TIMING)
    else $error("timing sent during NT PRBS");

  chk_lfsr_alive: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (prbs_ph && baud_tick) |=> (lfsr_r != 9'h000 && lfsr_r != $past(lfsr_r)))
    else $error("pattern generator stuck");

  chk_ternary_gate: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (!in_sync || !at_ternary) |=> !LINE_TERNARY)
    else $error("ternary sent without sync");

  chk_steady_info: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state_r == brla_pkg::BRLA_WAIT_DATA_VALID_STATE && in_sync && DATA_VALID) |=>
      (state_r == brla_pkg::BRLA_STEADY_STATE_OPERATION && TE_INFO_OUT == 3'h4))
    else $error("data valid did not reach steady state");

  chk_loss_pending: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (in_sync_state && !in_sync) |=> state_r == brla_pkg::BRLA_PENDING_DEACTIVATION_STATE)
    else $error("sync loss not handled");

  chk_pending_hold: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state_r == brla_pkg::BRLA_PENDING_DEACTIVATION_STATE && line_sig) |=> $stable(state_r))
    else $error("left pending with line signal present");

  chk_tone_length: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state_r == brla_pkg::BRLA_TERMINAL_ACTIVATION_STATE) |-> tone_cnt_r <= `BRLA_TONE_BAUDS)
    else $error("tone longer than set");

  chk_supv_expire: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state_r == brla_pkg::BRLA_TRAINING_STATE && supv_exp && !tone_rise) |=>
      state_r == brla_pkg::BRLA_PENDING_DEACTIVATION_STATE)
    else $error("supervision expiry ignored");

  chk_impossible_hold: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state_r == brla_pkg::BRLA_WAIT_TERMINAL_STATE && in_sync && TE_INFO != 3'h3) |=>
      ($stable(state_r) && $stable(TE_INFO_OUT)))
    else $error("state moved on impossible event");

  cov_steady: cover property (@(posedge CLK_SYS) disable iff (SYS_RST)
    state_r == brla_pkg::BRLA_STEADY_STATE_OPERATION && LINE_TERNARY);
  cov_pend_ready: cover property (@(posedge CLK_SYS) disable iff (SYS_RST)
    state_r == brla_pkg::BRLA_PENDING_DEACTIVATION_STATE ##1 state_r == brla_pkg::BRLA_READY_STATE);
  cov_user_wake: cover property (@(posedge CLK_SYS) disable iff (SYS_RST)
    state_r == brla_pkg::BRLA_TERMINAL_ACTIVATION_STATE ##1 state_r == brla_pkg::BRLA_TRAINING_STATE);
  cov_buf_full: cover property (@(posedge CLK_SYS) disable iff (SYS_RST) cnt_r == 2'h2);

endmodule : brla_nt_core

// file: tb/brla_lt_model.sv
`timescale 1ns/1ps
module brla_lt_model (
  output logic             line_clk,
  output logic             tone_det,
  output logic             line_sig,
  output logic             in_sync,
  input  wire logic        line_on,
  input  wire logic        tone_go,
  input  wire logic        sync_drop,
  input  wire logic [13:0] sync_off
);
  int   off;
  logic gained;
  assign line_sig = line_on;
  // A drop request forces loss of sync at once; a new tone clears sync until it is regained
  assign in_sync  = gained && !sync_drop;
  // Baud timebase, phase unrelated to the system clock
  initial begin
    line_clk = 1'b0;
    #37;
    forever #400 line_clk = ~line_clk;
  end
  initial begin
    tone_det = 1'b0;
    gained   = 1'b0;
    forever begin
      @(posedge tone_go);
      gained   = 1'b0;
      tone_det = 1'b1;
      repeat (128) @(posedge line_clk);
      tone_det = 1'b0;
      off = 0;
      while (off < sync_off) begin
        @(posedge line_clk);
        off++;
      end
      gained = 1'b1;
    end
  end
endmodule : brla_lt_model

// file: tb/brla_nt_core_bench.sv
`timescale 1ns/1ps
module brla_nt_core_bench;
  localparam logic [2:0] S_RDY = brla_pkg::BRLA_READY_STATE,
    S_TRN = brla_pkg::BRLA_TRAINING_STATE,
    S_WT  = brla_pkg::BRLA_WAIT_TERMINAL_STATE,
    S_WD  = brla_pkg::BRLA_WAIT_DATA_VALID_STATE,
    S_ST  = brla_pkg::BRLA_STEADY_STATE_OPERATION,
    S_TA  = brla_pkg::BRLA_TERMINAL_ACTIVATION_STATE,
    S_PD  = brla_pkg::BRLA_PENDING_DEACTIVATION_STATE,
    I0    = brla_pkg::BRLA_INFO0,
    I2    = brla_pkg::BRLA_INFO2,
    I4    = brla_pkg::BRLA_INFO4,
    NOI   = 3'h7;
  localparam logic [1:0] ZE = brla_pkg::BRLA_SYM_ZERO,
    PL = brla_pkg::BRLA_SYM_PLUS,
    MI = brla_pkg::BRLA_SYM_MINUS;
  logic        clk, rst, lclk, tdet, lsig, insync, dv, align, falign, tx_val;
  logic        tx_rdy, ltim, ltern, line_on, tone_go, sync_drop;
  logic [2:0]  te_info, info_out, st;
  logic [1:0]  tx_sym, lsym;
  logic [13:0] sync_off;
  logic [8:0]  s;
  logic        tim [0:10339];
  logic [1:0]  sym [0:10339];
  int          errors, checks, i, a, p, bad;

  brla_nt_core #(.SUPV_CYCLES(200), .DW(2)) i_dut (
    .CLK_SYS(clk), .SYS_RST(rst), .LINE_CLK(lclk), .TONE_DET(tdet), .LINE_SIG_DET(lsig),
    .IN_SYNC(insync), .DATA_VALID(dv), .TE_INFO(te_info), .ALIGN_EN(align), .FRAME_ALIGN(falign),
    .TX_SYM(tx_sym), .TX_VALID(tx_val), .TX_READY(tx_rdy), .LINE_SYM(lsym), .LINE_TIMING(ltim),
    .LINE_TERNARY(ltern), .TE_INFO_OUT(info_out), .NT_STATE(st));
  brla_lt_model i_lt (.line_clk(lclk), .tone_det(tdet), .line_sig(lsig), .in_sync(insync),
    .line_on(line_on), .tone_go(tone_go), .sync_drop(sync_drop), .sync_off(sync_off));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task note(input logic ok, input string m);
    checks++;
    if (!ok) begin
      errors++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask : note
  task cmp_code(input logic [2:0] g, input logic [2:0] e, input string m);
    note(g === e, m);
  endtask : cmp_code
  task cmp_sym(input logic [1:0] g, input logic [1:0] e, input string m);
    note(g === e, m);
  endtask : cmp_sym
  task cmp_flag(input logic g, input logic e, input string m);
    note(g === e, m);
  endtask : cmp_flag
  task cmp_num(input int g, input int e, input string m);
    note(g == e, m);
  endtask : cmp_num
  task wait_st(input logic [2:0] e, input logic [2:0] io, input string m);
    for (int k = 0; k < 8 && st !== e; k++) @(negedge clk);
    cmp_code(st, e, m);
    if (io !== NOI) cmp_code(info_out, io, m);
  endtask : wait_st

  task close_out;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  task t_reset;
    repeat (4) @(negedge clk);
    cmp_flag(tx_rdy, 1'b0, "room during reset");
    cmp_code(st, S_RDY, "state in reset");
    rst = 1'b0;
    @(negedge clk);
    cmp_code(st, S_RDY, "state after reset");
    cmp_flag(tx_rdy, 1'b1, "room after reset");
    $display("reset test done");
  endtask : t_reset

  task t_term;
    te_info = 3'h3;
    dv = 1'b1;
    repeat (4) @(negedge clk);
    cmp_code(st, S_RDY, "impossible event moved state");
    cmp_code(info_out, I0, "impossible event output");
    dv = 1'b0;
    te_info = 3'h1;
    wait_st(S_TA, I0, "terminal request");
    te_info = 3'h0;
    bad = 0;
    for (i = 0; i < 12 && lsym !== PL; i++) @(posedge lclk);
    for (i = 0; i < 132; i++) begin
      if (lsym !== (i >= 128 ? ZE : (i % 4 == 0 || i % 4 == 3) ? PL : MI)) bad++;
      @(posedge lclk);
    end
    cmp_num(bad, 0, "wake tone shape");
    $display("terminal test done");
  endtask : t_term

  task t_train;
    // Sync comes just after the pattern ends, well inside the supervision span
    sync_off = 14'd10310;
    line_on = 1'b1;
    tone_go = 1'b1;
    wait_st(S_TRN, I0, "line activation");
    @(negedge tdet);
    bad = 0;
    for (i = 0; i < 10340; i++) begin
      @(posedge lclk);
      tim[i] = ltim;
      sym[i] = lsym;
      if (ltern !== 1'b0) bad++;
    end
    cmp_num(bad, 0, "ternary before alignment");
    for (a = 0; a < 10340 && tim[a] !== 1'b1; a++);
    cmp_flag(a >= 574 && a <= 578, 1'b1, "first burst offset");
    bad = 0;
    for (i = 0; i < 10340; i++)
      if (tim[i] !== (i - a >= 0 && i - a < 512 || i - a >= 1024 && i - a < 1536)) bad++;
    cmp_num(bad, 0, "timing bursts");
    for (p = 0; p < 10340 && sym[p] === ZE; p++);
    // Symbols leave one baud after their offset is reached; timing follows the offset at once
    cmp_num(p - a, 5664 + 1, "pattern start");
    s = 9'h1ff;
    bad = 0;
    for (i = 0; i < 10340 - p; i++) begin
      if (sym[p + i] !== (i >= 4064 ? ZE : s[8] ? PL : MI)) bad++;
      s = {s[7:0], s[8] ^ s[3]};
    end
    cmp_num(bad, 0, "pattern body and end");
    $display("training test done");
  endtask : t_train

  task t_steady;
    wait_st(S_WT, I2, "line sync");
    te_info = 3'h3;
    wait_st(S_WD, I2, "terminal ready");
    dv = 1'b1;
    wait_st(S_ST, I4, "data valid");
    cmp_flag(ltern, 1'b0, "ternary before frame align");
    falign = 1'b1;
    repeat (2) @(negedge clk);
    cmp_flag(ltern, 1'b1, "ternary after align");
    $display("steady test done");
  endtask : t_steady

  task t_buffer;
    @(posedge lclk);
    repeat (4) @(negedge clk);
    cmp_flag(tx_rdy, 1'b1, "room when empty");
    tx_sym = MI;
    tx_val = 1'b1;
    @(negedge clk);
    tx_sym = PL;
    @(negedge clk);
    tx_val = 1'b0;
    @(negedge clk);
    cmp_flag(tx_rdy, 1'b0, "full after two");
    repeat (2) @(posedge lclk);
    cmp_sym(lsym, MI, "first word");
    @(posedge lclk);
    cmp_sym(lsym, PL, "second word");
    @(posedge lclk);
    cmp_sym(lsym, ZE, "empty sends zero");
    cmp_flag(tx_rdy, 1'b1, "room after drain");
    $display("buffer test done");
  endtask : t_buffer

  task t_loss;
    sync_drop = 1'b1;
    wait_st(S_PD, NOI, "sync loss in steady");
    cmp_flag(ltern, 1'b0, "ternary stops");
    sync_off = 14'd4;
    te_info = 3'h1;
    tone_go = 1'b0;
    @(negedge clk);
    tone_go = 1'b1;
    repeat (8) @(negedge clk);
    cmp_code(st, S_PD, "pending ignores events");
    te_info = 3'h0;
    dv = 1'b0;
    line_on = 1'b0;
    wait_st(S_RDY, I0, "line silent");
    $display("loss test done");
  endtask : t_loss

  task t_retrain;
    for (i = 0; i < 1500 && tdet !== 1'b0; i++) @(negedge clk);
    repeat (64) @(negedge clk);
    line_on = 1'b1;
    tone_go = 1'b0;
    @(negedge clk);
    tone_go = 1'b1;
    sync_drop = 1'b0;
    wait_st(S_TRN, I0, "activation from ready");
    for (i = 0; i < 1500 && st !== S_WT; i++) @(negedge clk);
    wait_st(S_WT, I2, "sync after retrain");
    sync_drop = 1'b1;
    wait_st(S_PD, NOI, "sync loss in wait");
    $display("retrain test done");
  endtask : t_retrain

  initial begin
    repeat (95000) @(posedge clk);
    errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    close_out;
  end

  initial begin
    rst = 1'b1;
    te_info = 3'h0;
    dv = 1'b0;
    align = 1'b1;
    falign = 1'b0;
    tx_sym = ZE;
    tx_val = 1'b0;
    line_on = 1'b0;
    tone_go = 1'b0;
    sync_drop = 1'b0;
    sync_off = 14'd0;
    t_reset;
    t_term;
    t_train;
    t_steady;
    t_buffer;
    t_loss;
    t_retrain;
    close_out;
  end
endmodule : brla_nt_core_bench
